// File: rtl/pcsia_core.sv
// Program counter, return stack and indirect data addressing
//
// Function
// RULE1: Program counter is thirteen bits wide.
// RULE2: Low PC byte is readable and writable as pc_low_byte_reg.
// RULE3: PC bits 12:8 are never accessed directly; loaded from pc_high_latch.
// RULE4: Any reset clears the whole program counter.
// RULE5: Writing pc_low_byte_reg loads PC bits 12:8 from latch bits 4:0.
// RULE6: CALL or GOTO takes latch bits 4:3 plus eleven operand bits.
// RULE7: Return stack holds eight 13-bit entries outside memory spaces.
// RULE8: Stack pointer cannot be read or written by software.
// RULE9: CALL or interrupt vectoring pushes the program counter.
// RULE10: RETURN, return_with_literal, return_from_interrupt pop into PC.
// RULE11: Push and pop leave pc_high_latch unchanged.
// RULE12: Stack is circular; ninth push overwrites the first entry.
// RULE13: No overflow or underflow indication; wrapping is silent.
// RULE14: indirect_data_port is not storage; it accesses data at pointer.
// RULE15: Indirect read of indirect_data_port itself returns zero.
// RULE16: Indirect write of indirect_data_port itself stores nothing.
// RULE17: Indirect address is bank bit above the eight pointer bits.
// RULE18: Otherwise PC increments by one per instruction, wrapping.
`include "pcsia_defs.svh"
`default_nettype none
module pcsia_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pcsia_pkg::pcsia_bus_s bus,
  input wire pcsia_pkg::pcsia_flow_s flow,
  input wire logic indirect_bank_bit,
  output logic [7:0] rd_data,
  output pcsia_pkg::pcsia_addr_t pc
);

  pcsia_pkg::pcsia_state_s s;
  pcsia_pkg::pcsia_state_s next_s;
  logic [7:0] ram [`PCSIA_RAM_WORDS];
  logic [8:0] ind_addr;
  logic ind_self;
  logic push;
  logic pop;
  pcsia_pkg::pcsia_addr_t pc_inc;
  pcsia_pkg::pcsia_addr_t push_val;

  // Effective indirect address
  assign ind_addr = {indirect_bank_bit, s.fsp}; // see RULE17
  assign ind_self = (s.fsp[6:0] == `PCSIA_IND_SELF);
  assign pc_inc = `PCSIA_PC_W'(s.pc + 13'h0001); // see RULE18

  // Stack actions, interrupt first
  assign push = flow.irq | (!flow.ret & flow.jump & flow.call); // see RULE9
  assign pop = !flow.irq & flow.ret; // see RULE10
  assign push_val = flow.irq ? s.pc : pc_inc;

  always_comb begin
    next_s = s;
    next_s.rd_data = 8'h00;
    // Register reads; stack pointer never visible, see RULE8
    if (bus.rd) begin
      if (bus.addr == `PCSIA_A_IND) begin
        next_s.rd_data = ind_self ? 8'h00 : ram[ind_addr]; // see RULE15
      end else if (bus.addr == `PCSIA_A_PCLOW) begin
        next_s.rd_data = s.pc[7:0]; // see RULE2
      end else if (bus.addr == `PCSIA_A_HLATCH) begin
        next_s.rd_data = {3'h0, s.hlatch};
      end else if (bus.addr == `PCSIA_A_FSP) begin
        next_s.rd_data = s.fsp;
      end else begin
        next_s.rd_data = 8'h00;
      end
    end
    if (bus.wr) begin
      if (bus.addr == `PCSIA_A_HLATCH) begin
        next_s.hlatch = bus.wdata[4:0];
      end else if (bus.addr == `PCSIA_A_FSP) begin
        next_s.fsp = bus.wdata;
      end
    end
    // Circular stack, silent wrap, see RULE12 and RULE13
    if (push) begin
      next_s.stack[s.sp] = push_val; // see RULE7
      next_s.sp = 3'(s.sp + 3'h1);
    end else if (pop) begin
      next_s.sp = 3'(s.sp - 3'h1);
    end
    // Program counter source, see RULE1 and RULE3
    if (flow.irq) begin
      next_s.pc = `PCSIA_VECTOR;
    end else if (flow.ret) begin
      next_s.pc = s.stack[3'(s.sp - 3'h1)]; // see RULE10
    end else if (flow.jump) begin
      next_s.pc = {s.hlatch[`PCSIA_HL_ALL_MSB:`PCSIA_HL_PAGE_LSB],
                   flow.operand}; // see RULE6
    end else if (bus.wr && bus.addr == `PCSIA_A_PCLOW) begin
      next_s.pc = {s.hlatch, bus.wdata}; // see RULE5
    end else if (flow.step) begin
      next_s.pc = pc_inc; // see RULE18
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0; // see RULE4
    end else begin
      s <= next_s;
    end
  end

  // Data memory reached only through the pointer
  always_ff @(posedge mclk) begin
    if (bus.wr && bus.addr == `PCSIA_A_IND && !ind_self) begin
      ram[ind_addr] <= bus.wdata; // see RULE14 RULE16
    end
  end

  assign pc = s.pc;
  assign rd_data = s.rd_data;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence call_seq;
    flow.jump && flow.call && !flow.irq && !flow.ret;
  endsequence

  sequence ret_seq;
    flow.ret && !flow.irq;
  endsequence

  reset_clears_pc_a: assert property ( // see RULE4
    @(posedge mclk) disable iff (1'b0) !rst_n |=> pc == `PCSIA_PC_RST)
    else $error("pc not cleared by reset");

  pcl_write_load_a: assert property ( // see RULE5
    bus.wr && bus.addr == `PCSIA_A_PCLOW && !flow.irq && !flow.ret
    && !flow.jump |=> pc == {$past(s.hlatch), $past(bus.wdata)})
    else $error("low byte write loaded wrong pc");

  goto_page_a: assert property ( // see RULE6
    flow.jump && !flow.irq && !flow.ret |=>
    pc[12:11] == $past(s.hlatch[4:3]) && pc[10:0] == $past(flow.operand))
    else $error("jump target wrong");

  call_return_a: assert property ( // see RULE9 RULE10
    call_seq ##1 ret_seq |=> pc == 13'($past(pc, 2) + 13'h0001))
    else $error("return did not resume after call");

  latch_kept_a: assert property ( // see RULE11
    (push || pop) && !bus.wr |=> s.hlatch == $past(s.hlatch))
    else $error("stack action changed high latch");

  irq_vector_a: assert property ( // see RULE9
    flow.irq |=> pc == `PCSIA_VECTOR && s.sp == 3'($past(s.sp) + 3'h1)
    && s.stack[$past(s.sp)] == $past(pc))
    else $error("interrupt entry wrong");

  stack_wrap_a: assert property ( // see RULE12 RULE13
    push && s.sp == 3'h7 |=> s.sp == `PCSIA_SP_RST)
    else $error("stack did not wrap");

  self_read_a: assert property ( // see RULE15
    bus.rd && bus.addr == `PCSIA_A_IND && ind_self |=> rd_data == 8'h00)
    else $error("self indirect read not zero");

  self_write_a: assert property ( // see RULE16
    bus.wr && bus.addr == `PCSIA_A_IND && ind_self |=>
    ram[$past(ind_addr)] == $past(ram[ind_addr]))
    else $error("self indirect write stored data");

  bank_read_a: assert property ( // see RULE14 RULE17
    bus.rd && bus.addr == `PCSIA_A_IND && !ind_self |=>
    rd_data == ram[$past({indirect_bank_bit, s.fsp})])
    else $error("indirect read wrong location");

  pc_step_a: assert property ( // see RULE18
    flow.step && !flow.irq && !flow.ret && !flow.jump && !bus.wr |=>
    pc == 13'($past(pc) + 13'h0001))
    else $error("pc did not increment");

  sequence step_only_seq;
    flow.step && !flow.irq && !flow.ret && !flow.jump && !bus.wr;
  endsequence

  sequence irq_seq;
    flow.irq;
  endsequence

  // Read port answers and idle level
  rd_idle_zero_a: assert property ( // see RULE2
    !bus.rd |=>
    rd_data == 8'h00)
    else $error("read data not idle zero");

  pcl_read_a: assert property ( // see RULE2
    bus.rd && bus.addr == `PCSIA_A_PCLOW |=>
    rd_data == $past(pc[7:0]))
    else $error("low byte read wrong");

  latch_read_a: assert property ( // see RULE3
    bus.rd && bus.addr == `PCSIA_A_HLATCH |=>
    rd_data == {3'h0, $past(s.hlatch)})
    else $error("high latch read wrong");

  latch_upper_zero_a: assert property ( // see RULE3
    bus.rd && bus.addr == `PCSIA_A_HLATCH |=>
    rd_data[7:5] == 3'h0)
    else $error("high latch upper bits not zero");

  fsp_read_a: assert property ( // see RULE14
    bus.rd && bus.addr == `PCSIA_A_FSP |=>
    rd_data == $past(s.fsp))
    else $error("pointer read wrong");

  unmapped_read_a: assert property ( // see RULE8
    bus.rd && bus.addr > `PCSIA_A_FSP |=>
    rd_data == 8'h00)
    else $error("unmapped read not zero");

  // Register writes and holds
  latch_write_a: assert property ( // see RULE3
    bus.wr && bus.addr == `PCSIA_A_HLATCH |=>
    s.hlatch == $past(bus.wdata[4:0]))
    else $error("high latch write lost");

  fsp_write_a: assert property ( // see RULE17
    bus.wr && bus.addr == `PCSIA_A_FSP |=>
    s.fsp == $past(bus.wdata))
    else $error("pointer write lost");

  latch_hold_a: assert property ( // see RULE11
    !(bus.wr && bus.addr == `PCSIA_A_HLATCH) |=>
    $stable(s.hlatch))
    else $error("high latch changed without write");

  fsp_hold_a: assert property ( // see RULE14
    !(bus.wr && bus.addr == `PCSIA_A_FSP) |=>
    $stable(s.fsp))
    else $error("pointer changed without write");

  pcl_keeps_latch_a: assert property ( // see RULE5
    bus.wr && bus.addr == `PCSIA_A_PCLOW |=>
    $stable(s.hlatch))
    else $error("low byte write changed latch");

  vector_no_latch_a: assert property ( // see RULE11
    flow.irq && !bus.wr |=>
    $stable(s.hlatch))
    else $error("interrupt entry changed latch");

  // Program counter stepping and holding
  pc_hold_a: assert property ( // see RULE18
    !flow.step && !flow.irq && !flow.ret && !flow.jump
    && !(bus.wr && bus.addr == `PCSIA_A_PCLOW) |=> $stable(pc))
    else $error("pc moved without cause");

  pc_upper_kept_a: assert property ( // see RULE3
    step_only_seq ##0 (pc[7:0] != 8'hff) |=>
    pc[12:8] == $past(pc[12:8]))
    else $error("upper pc bits changed on step");

  page_carry_a: assert property ( // see RULE18
    step_only_seq ##0 (pc[7:0] == 8'hff) |=>
    pc[12:8] == 5'($past(pc[12:8]) + 5'h01))
    else $error("step did not carry into upper bits");

  pc_wrap_a: assert property ( // see RULE1
    step_only_seq ##0 (pc == 13'h1fff) |=>
    pc == 13'h0000)
    else $error("pc did not wrap in thirteen bits");

  read_no_state_a: assert property ( // see RULE8
    bus.rd && !flow.step && !flow.irq && !flow.ret && !flow.jump |=>
    $stable(pc) && $stable(s.sp))
    else $error("register read moved pc or stack");

  // Return stack
  ret_pop_a: assert property ( // see RULE10
    ret_seq |=>
    pc == $past(s.stack[3'(s.sp - 3'h1)]))
    else $error("return popped wrong entry");

  pop_sp_a: assert property ( // see RULE13
    ret_seq |=>
    s.sp == 3'($past(s.sp) - 3'h1))
    else $error("pop moved stack pointer wrongly");

  ret_keeps_stack_a: assert property ( // see RULE10
    ret_seq |=>
    $stable(s.stack))
    else $error("return changed stack contents");

  call_push_a: assert property ( // see RULE9
    call_seq |=>
    s.stack[$past(s.sp)] == 13'($past(pc) + 13'h0001))
    else $error("call pushed wrong address");

  call_sp_a: assert property ( // see RULE12
    call_seq |=>
    s.sp == 3'($past(s.sp) + 3'h1))
    else $error("call moved stack pointer wrongly");

  goto_no_push_a: assert property ( // see RULE9
    flow.jump && !flow.call && !flow.irq && !flow.ret |=>
    $stable(s.sp) && $stable(s.stack))
    else $error("goto touched the stack");

  sp_hold_a: assert property ( // see RULE8
    !push && !pop |=>
    $stable(s.sp))
    else $error("stack pointer moved without cause");

  stack_hold_a: assert property ( // see RULE7
    !push |=>
    $stable(s.stack))
    else $error("stack changed without push");

  pop_wrap_a: assert property ( // see RULE13
    pop && s.sp == 3'h0 |=>
    s.sp == 3'h7)
    else $error("stack underflow did not wrap");

  pcl_no_push_a: assert property ( // see RULE8
    bus.wr && !flow.irq && !flow.ret && !flow.jump |=>
    $stable(s.sp))
    else $error("register write moved stack pointer");

  nested_call_a: assert property ( // see RULE12
    call_seq ##1 call_seq ##1 ret_seq ##1 ret_seq |=>
    pc == 13'($past(pc, 4) + 13'h0001))
    else $error("nested calls did not unwind");

  irq_return_a: assert property ( // see RULE10
    irq_seq ##1 ret_seq |=>
    pc == $past(pc, 2))
    else $error("return from interrupt wrong");

  // Indirect access
  ind_write_a: assert property ( // see RULE14
    bus.wr && bus.addr == `PCSIA_A_IND && !ind_self |=>
    ram[$past(ind_addr)] == $past(bus.wdata))
    else $error("indirect write lost");

  ind_read_fsp_a: assert property ( // see RULE14
    bus.rd && bus.addr == `PCSIA_A_IND |=>
    $stable(s.fsp))
    else $error("indirect read changed pointer");

  ind_write_fsp_a: assert property ( // see RULE16
    bus.wr && bus.addr == `PCSIA_A_IND |=>
    $stable(s.fsp))
    else $error("indirect write changed pointer");

  // Priorities between flow events
  irq_over_ret_a: assert property ( // see RULE9
    flow.irq && flow.ret |=>
    pc == `PCSIA_VECTOR && s.sp == 3'($past(s.sp) + 3'h1))
    else $error("interrupt lost against return");

  irq_over_call_a: assert property ( // see RULE9
    flow.irq && flow.jump |=>
    pc == `PCSIA_VECTOR)
    else $error("interrupt lost against jump");

  ret_over_jump_a: assert property ( // see RULE10
    flow.ret && flow.jump && !flow.irq |=>
    s.sp == 3'($past(s.sp) - 3'h1))
    else $error("return lost against jump");

  jump_over_pcl_a: assert property ( // see RULE6
    flow.jump && !flow.irq && !flow.ret && bus.wr |=>
    pc[10:0] == $past(flow.operand))
    else $error("jump lost against low byte write");

  reset_state_a: assert property ( // see RULE4
    @(posedge mclk) disable iff (1'b0) !rst_n |=>
    s.sp == `PCSIA_SP_RST && s.hlatch == 5'h00 && rd_data == 8'h00)
    else $error("reset left state behind");

endmodule : pcsia_core
`default_nettype wire

// File: rtl/pcsia_defs.svh
// Offsets, field positions, reset values and sizes of the PC/stack block
`ifndef PCSIA_DEFS_SVH
`define PCSIA_DEFS_SVH

// Register port addresses
`define PCSIA_A_IND 3'h0
`define PCSIA_A_PCLOW 3'h1
`define PCSIA_A_HLATCH 3'h2
`define PCSIA_A_FSP 3'h3

// Field positions
`define PCSIA_HL_ALL_MSB 4
`define PCSIA_HL_PAGE_LSB 3
`define PCSIA_OPND_MSB 10

// Sizes
`define PCSIA_PC_W 13
`define PCSIA_DEPTH 8
`define PCSIA_RAM_WORDS 512

// Reset values
`define PCSIA_PC_RST 13'h0000
`define PCSIA_SP_RST 3'h0

// Location of the indirect port itself within each bank
`define PCSIA_IND_SELF 7'h00

// Default interrupt vector
`define PCSIA_VECTOR 13'h0004

`endif

// File: rtl/pcsia_pkg.sv
// Types of the PC, stack and indirect addressing block
`default_nettype none
package pcsia_pkg;

  typedef logic [12:0] pcsia_addr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } pcsia_bus_s;

  typedef struct packed {
    logic step;
    logic jump;
    logic call;
    logic ret;
    logic irq;
    logic [10:0] operand;
  } pcsia_flow_s;

  typedef struct packed {
    pcsia_addr_t pc;
    logic [4:0] hlatch;
    logic [7:0] fsp;
    logic [2:0] sp;
    pcsia_addr_t [7:0] stack;
    logic [7:0] rd_data;
  } pcsia_state_s;

endpackage : pcsia_pkg
`default_nettype wire

// File: verification/pc_stack_indirect_addressing_bench.sv
// Self-checking bench for the PC, stack and indirect addressing block
`default_nettype none
module pc_stack_indirect_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, bank;
  pcsia_pkg::pcsia_bus_s bus;
  pcsia_pkg::pcsia_flow_s flow;
  logic [7:0] rd_data;
  pcsia_pkg::pcsia_addr_t pc, ep;
  pcsia_pkg::pcsia_addr_t sm [8];
  logic [2:0] sp;
  int err_total, samples_checked;
  // Step, goto, call, interrupt, two returns
  logic [15:0] rows [6] = '{16'h8000, 16'h4123, 16'h6005, 16'h0800,
    16'h1000, 16'h1000};
  pcsia_pkg::pcsia_addr_t rows_pc [6] = '{13'h1f35, 13'h1923, 13'h1805,
    13'h0004, 13'h1805, 13'h1924};
  pcsia_core dut_u (.mclk(mclk), .rst_n(rst_n), .bus(bus), .flow(flow),
    .indirect_bank_bit(bank), .rd_data(rd_data), .pc(pc));
  pcsia_flow_model flow_u (.mclk(mclk), .flow(flow));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [12:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= {2'b10, a, d};
    @(posedge mclk);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus <= {2'b01, a, 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk("rd_data", {5'h00, rd_data}, {5'h00, e});
  endtask : rd
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    err_total++;
    end_sim;
  end
  initial begin
    rst_n = 1'b0;
    bank = 1'b0;
    bus = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(posedge mclk);
    #1 chk("pc", pc, 13'h0000);
    @(posedge mclk);
    rst_n <= 1'b1;
    wr(3'h2, 8'h1f);
    wr(3'h1, 8'h34);
    chk("pc", pc, 13'h1f34);
    rd(3'h1, 8'h34);
    for (int i = 0; i < 6; i++) begin
      flow_u.issue(rows[i]);
      chk("pc", pc, rows_pc[i]);
    end
    ep = 13'h1924;
    sp = 3'h0;
    for (int i = 0; i < 9; i++) begin
      sm[sp] = ep + 13'h0001;
      sp++;
      flow_u.issue(16'h6000 | 16'(i));
      ep = 13'h1800 + 13'(i);
      chk("pc", pc, ep);
    end
    rd(3'h2, 8'h1f);
    for (int i = 0; i < 9; i++) begin
      sp--;
      flow_u.issue(16'h1000);
      chk("pc", pc, sm[sp]);
    end
    wr(3'h3, 8'h20);
    wr(3'h0, 8'h5a);
    wr(3'h3, 8'h21);
    wr(3'h0, 8'h11);
    @(posedge mclk);
    bank <= 1'b1;
    wr(3'h3, 8'h20);
    wr(3'h0, 8'h77);
    rd(3'h0, 8'h77);
    @(posedge mclk);
    bank <= 1'b0;
    rd(3'h0, 8'h5a);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h00);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk("pc", pc, 13'h0000);
    rd(3'h2, 8'h00);
    end_sim;
  end
endmodule : pc_stack_indirect_addressing_bench
`default_nettype wire

// File: verification/pcsia_flow_model.sv
// Model of the instruction sequencer that drives the flow port
`default_nettype none
module pcsia_flow_model (
  input wire logic mclk,
  output var pcsia_pkg::pcsia_flow_s flow
);
  timeunit 1ns;
  timeprecision 1ps;
  initial flow = '0;
  // One instruction event for one cycle, then idle
  task automatic issue(input logic [15:0] v);
    @(posedge mclk);
    flow <= v;
    @(posedge mclk);
    flow <= '0;
    #1;
  endtask : issue
endmodule : pcsia_flow_model
`default_nettype wire
